/* hdl/fan_pwm_tach_control.sv */
// Fan PWM generator with lookup-table duty and tachometer period counter.
// Assumes a 50 MHz clock, synchronous inputs and a simple register port.
//
// Function
// - Five-bit frequency; full scale is twice it.
// - PWM rate is base clock over twice setting.
// - High time is value over full scale.
// - Config bit picks 1.4 kHz or 360 kHz.
// - Count 90 kHz ticks over two tach periods.
// - Tach count is low plus 256 times high.
// - Eight temperature and PWM pairs form table.
`timescale 1ns/1ps
module fan_pwm_tach_control
    import fan_pkg::*;
#(
    parameter int SLOW_DIV = PWM_SLOW_DIV
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire reg_req_t   reg_req,
    output logic [7:0]      reg_rdata_q,
    input  wire logic [7:0] remote_temp,
    input  wire logic       tach_in,
    output logic            fan_pwm_q
);
    // Configuration storage.
    logic [7:0] fan_cfg_q;
    logic [7:0] spinup_q;
    logic [7:0] duty_q;
    logic [7:0] freq_q;
    logic [7:0] lut_temp_q [LUT_STEPS];
    logic [7:0] lut_pwm_q  [LUT_STEPS];

    // PWM and tach state.
    logic [5:0]  pwm_cnt_q;
    logic [15:0] tach_run_q;
    logic [15:0] tach_count_q;
    logic        tach_prev_q;
    logic        tach_seen_q;
    logic        tach_half_q;

    // Divided ticks.
    logic fast_tick;
    logic slow_tick;
    logic tach_tick;

    tick_divider #(.DIV(PWM_FAST_DIV)) u_fast_div (
        .clk    (clk),
        .resetn (resetn),
        .tick_q (fast_tick)
    );

    tick_divider #(.DIV(SLOW_DIV)) u_slow_div (
        .clk    (clk),
        .resetn (resetn),
        .tick_q (slow_tick)
    );

    tick_divider #(.DIV(TACH_DIV)) u_tach_div (
        .clk    (clk),
        .resetn (resetn),
        .tick_q (tach_tick)
    );

    // Address decode for the register port.
    wire       is_lut    = (reg_req.addr >= LUT_FIRST_ADDR) && (reg_req.addr <= LUT_LAST_ADDR);
    wire [2:0] lut_idx   = reg_req.addr[3:1];
    wire       lut_odd   = reg_req.addr[0];
    wire       wr_cfg    = reg_req.wr && (reg_req.addr == FAN_CFG_ADDR);
    wire       wr_spin   = reg_req.wr && (reg_req.addr == SPINUP_ADDR);
    wire       wr_duty   = reg_req.wr && (reg_req.addr == DUTY_ADDR);
    wire       wr_freq   = reg_req.wr && (reg_req.addr == FREQ_ADDR);
    wire       wr_lut    = reg_req.wr && is_lut;

    // Read selection; unmapped addresses read as zero.
    wire [7:0] lut_rd    = lut_odd ? lut_pwm_q[lut_idx] : lut_temp_q[lut_idx];
    wire [7:0] rd_mux    = (reg_req.addr == TACH_LOW_ADDR)  ? tach_count_q[7:0]  :
                           (reg_req.addr == TACH_HIGH_ADDR) ? tach_count_q[15:8] :
                           (reg_req.addr == FAN_CFG_ADDR)   ? fan_cfg_q          :
                           (reg_req.addr == SPINUP_ADDR)    ? spinup_q           :
                           (reg_req.addr == DUTY_ADDR)      ? duty_q             :
                           (reg_req.addr == FREQ_ADDR)      ? freq_q             :
                           is_lut                           ? lut_rd             : 8'h00;

    // Zero setting is treated as one so the period never collapses.
    wire [4:0] eff_freq  = (freq_q[4:0] == 5'h0) ? 5'h1 : freq_q[4:0];
    wire [5:0] eff_full  = {eff_freq, 1'b0};
    wire       clk_slow  = fan_cfg_q[CFG_CLK_SEL_BIT];
    wire       pwm_tick  = clk_slow ? slow_tick : fast_tick;
    wire       pwm_wrap  = (pwm_cnt_q >= eff_full - 6'd1);
    wire       direct    = fan_cfg_q[CFG_DIRECT_BIT];

    // Highest table entry whose temperature is not above the reading.
    logic [5:0] lut_duty;
    always_comb begin
        lut_duty = 6'h00;
        for (int i = 0; i < LUT_STEPS; i++) begin
            if (lut_temp_q[i] <= remote_temp) begin
                lut_duty = lut_pwm_q[i][5:0];
            end
        end
    end

    wire [5:0] duty_sel  = direct ? duty_q[5:0] : lut_duty;
    // Full-scale duty stays high even while a lowered setting waits to wrap.
    wire       full_on   = (duty_sel >= eff_full);
    wire       high_d    = full_on || (pwm_cnt_q < duty_sel);
    wire       tach_rise = tach_in && !tach_prev_q;
    wire       tach_end  = tach_rise && (tach_half_q || !tach_seen_q);
    wire       tach_sat  = (tach_run_q == 16'hFFFF);

    // Register writes; only the documented bits are stored.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fan_cfg_q <= FAN_CFG_RESET;
            spinup_q  <= SPINUP_RESET;
            duty_q    <= DUTY_RESET;
            freq_q    <= FREQ_RESET;
        end else begin
            if (wr_cfg)  fan_cfg_q <= reg_req.wdata & FAN_CFG_MASK;
            if (wr_spin) spinup_q  <= reg_req.wdata & SPINUP_MASK;
            if (wr_duty) duty_q    <= reg_req.wdata & DUTY_MASK;
            if (wr_freq) freq_q    <= reg_req.wdata & FREQ_MASK;
        end
    end

    // Lookup table storage, one temperature and one PWM value per step.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < LUT_STEPS; i++) begin
                lut_temp_q[i] <= LUT_RESET;
                lut_pwm_q[i]  <= LUT_RESET;
            end
        end else if (wr_lut) begin
            if (lut_odd) lut_pwm_q[lut_idx]  <= reg_req.wdata & LUT_PWM_MASK;
            else         lut_temp_q[lut_idx] <= reg_req.wdata;
        end
    end

    // Read data is registered so the port sees a stable byte.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_q <= RDATA_RESET;
        end else if (reg_req.rd) begin
            reg_rdata_q <= rd_mux;
        end
    end

    // PWM counter steps on the selected base tick; wrap also catches a
    // frequency lowered mid-period, so the counter cannot run away.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwm_cnt_q <= 6'h00;
            fan_pwm_q <= 1'b0;
        end else begin
            if (pwm_tick) pwm_cnt_q <= pwm_wrap ? 6'h00 : pwm_cnt_q + 6'd1;
            fan_pwm_q <= high_d ^ fan_cfg_q[CFG_POLARITY_BIT];
        end
    end

    // Tach count spans two tach periods, one turn of a two-pulse fan, so the
    // host speed formula holds; the first edge after reset only arms the count.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tach_prev_q  <= 1'b0;
            tach_seen_q  <= 1'b0;
            tach_half_q  <= 1'b0;
            tach_run_q   <= 16'h0000;
            tach_count_q <= 16'h0000;
        end else begin
            tach_prev_q <= tach_in;
            if (tach_rise) begin
                tach_seen_q <= 1'b1;
                tach_half_q <= tach_seen_q && !tach_half_q;
            end
            if (tach_end) begin
                if (tach_seen_q) tach_count_q <= tach_run_q;
                tach_run_q <= 16'h0000;
            end else if (tach_tick && !tach_sat) begin
                tach_run_q <= tach_run_q + 16'd1;
            end
        end
    end

    // Checks on the logic above.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_full_scale: assert property (eff_full == 6'(2 * eff_freq) && eff_full <= 6'd62)
        else $error("full scale is not twice the frequency setting");
    chk_zero_freq: assert property (freq_q[4:0] == 5'h0 |-> eff_full == 6'd2)
        else $error("zero frequency setting not treated as one");
    chk_period_wrap: assert property (pwm_tick && pwm_cnt_q == eff_full - 6'd1 |=> pwm_cnt_q == 6'h00)
        else $error("pwm counter did not wrap at full scale");
    chk_clock_pick: assert property (clk_slow && !slow_tick |=> $stable(pwm_cnt_q))
        else $error("pwm counter moved without a slow tick");
    chk_fast_pick: assert property (!clk_slow && !fast_tick |=> $stable(pwm_cnt_q))
        else $error("pwm counter moved without a fast tick");
    chk_full_duty: assert property ((duty_sel >= eff_full && !fan_cfg_q[CFG_POLARITY_BIT])[*2] |-> fan_pwm_q)
        else $error("full duty did not hold output high");
    chk_zero_duty: assert property ((duty_sel == 6'h00 && !fan_cfg_q[CFG_POLARITY_BIT])[*2] |-> !fan_pwm_q)
        else $error("zero duty did not hold output low");
    chk_tach_latch: assert property (tach_rise && tach_half_q |=> tach_count_q == $past(tach_run_q) && tach_run_q == 16'h0000)
        else $error("tach count not latched on edge");
    chk_tach_read: assert property (reg_req.rd && reg_req.addr == TACH_HIGH_ADDR |=> reg_rdata_q == $past(tach_count_q[15:8]))
        else $error("tach high byte read mismatch");
    chk_lut_top: assert property (!direct && lut_temp_q[7] <= remote_temp |-> duty_sel == lut_pwm_q[7][5:0])
        else $error("table top entry not applied");

    cov_tach_edge: cover property (tach_rise ##1 tach_count_q != 16'h0000);
    cov_pwm_wrap:  cover property (pwm_tick && pwm_wrap);
    cov_lut_mode:  cover property (!direct && lut_duty != 6'h00);
endmodule

/* pkg/fan_pkg.sv */
// Package for the fan PWM and tachometer block: register map, field
// positions, reset values and clock rate constants.
// Assumes a single 50 MHz system clock drives all of the logic.
package fan_pkg;

    // Register offsets.
    localparam logic [7:0] TACH_LOW_ADDR   = 8'h46;
    localparam logic [7:0] TACH_HIGH_ADDR  = 8'h47;
    localparam logic [7:0] FAN_CFG_ADDR    = 8'h4A;
    localparam logic [7:0] SPINUP_ADDR     = 8'h4B;
    localparam logic [7:0] DUTY_ADDR       = 8'h4C;
    localparam logic [7:0] FREQ_ADDR       = 8'h4D;
    localparam logic [7:0] LUT_FIRST_ADDR  = 8'h50;
    localparam logic [7:0] LUT_LAST_ADDR   = 8'h5F;

    // Fan configuration field positions.
    localparam int CFG_CLK_SEL_BIT  = 3;
    localparam int CFG_POLARITY_BIT = 4;
    localparam int CFG_DIRECT_BIT   = 5;

    // Writable masks; reserved bits read back as zero.
    localparam logic [7:0] FAN_CFG_MASK   = 8'h3B;
    localparam logic [7:0] SPINUP_MASK    = 8'h3F;
    localparam logic [7:0] DUTY_MASK      = 8'h3F;
    localparam logic [7:0] FREQ_MASK      = 8'h1F;
    localparam logic [7:0] LUT_PWM_MASK   = 8'h3F;

    // Values after reset.
    localparam logic [7:0] FAN_CFG_RESET  = 8'h20;
    localparam logic [7:0] SPINUP_RESET   = 8'h00;
    localparam logic [7:0] DUTY_RESET     = 8'h00;
    localparam logic [7:0] FREQ_RESET     = 8'h01;
    localparam logic [7:0] LUT_RESET      = 8'h00;
    localparam logic [7:0] RDATA_RESET    = 8'h00;

    localparam int LUT_STEPS = 8;

    // Clock rates in Hz and the cycle counts derived from them.
    localparam int CLK_HZ       = 50_000_000;
    localparam int PWM_FAST_HZ  = 360_000;
    localparam int PWM_SLOW_HZ  = 1_400;
    localparam int TACH_HZ      = 90_000;
    localparam int PWM_FAST_DIV = CLK_HZ / PWM_FAST_HZ;
    localparam int PWM_SLOW_DIV = CLK_HZ / PWM_SLOW_HZ;
    localparam int TACH_DIV     = CLK_HZ / TACH_HZ;

    // One register access from the host side.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* hdl/tick_divider.sv */
// Divider that turns the system clock into a one-cycle enable pulse.
// Assumes a synchronous active-low reset in the system clock domain.
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = 139
) (
    input  wire logic clk,
    input  wire logic resetn,
    output logic      tick_q
);
    localparam int CW = $clog2(DIV + 1);

    logic [CW-1:0] cnt_q;
    wire           last = (cnt_q == CW'(DIV - 1));

    // Count to DIV and pulse once per wrap.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= last ? '0 : cnt_q + 1'b1;
            tick_q <= last;
        end
    end
endmodule

/* tb/fan_model.sv */
// Behavioural fan: the rotor starts on its first drive pulse, then the
// tach line toggles every HALF clocks, two pulses per turn.
// Assumes the drive level is synchronous to clk.
`timescale 1ns/1ps
module fan_model #(
    parameter int HALF = 10000
) (
    input  wire logic clk,
    input  wire logic pwm,
    output logic      tach
);
    int   cnt  = 0;
    logic spin = 1'b0;
    initial tach = 1'b0;
    // A stalled fan gives no tach edges, so the count waits for real drive.
    always @(posedge clk) begin
        if (pwm === 1'b1) spin <= 1'b1;
        if (spin) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) tach <= ~tach;
        end
    end
endmodule

/* tb/tb_fan_pwm_tach_control.sv */
// Self-checking bench for the fan PWM and tach block.
// Assumes fan_pkg and a behavioural fan on the tach input.
`timescale 1ns/1ps
module tb_fan_pwm_tach_control;
    import fan_pkg::*;
    localparam int SLOW = 4;
    localparam int FAST = PWM_FAST_DIV;
    localparam int HALF = 5000;
    // Two tach periods of the fan model in 90 kHz ticks, and its true speed.
    localparam int TACH_EXP = 4 * HALF / TACH_DIV;
    localparam int RPM_EXP  = 15 * CLK_HZ / HALF;
    logic        clk    = 1'b0;
    logic        resetn = 1'b0;
    reg_req_t    req    = '0;
    logic [7:0]  rdata;
    logic [7:0]  temp   = 8'h00;
    logic        tach;
    logic        pwm;
    logic [7:0]  v;
    logic [7:0]  lo;
    logic [31:0] seed   = 32'h0000_3480;
    int fail_count = 0;
    int checked    = 0;
    int cyc        = 0;
    int f;
    int d;
    bit pol;
    int cf[3] = '{0, 31, 24};
    int cd[3] = '{1, 62, 28};

    fan_pwm_tach_control #(.SLOW_DIV(SLOW)) i_fan_pwm_tach_control (
        .clk(clk), .resetn(resetn), .reg_req(req), .reg_rdata_q(rdata),
        .remote_temp(temp), .tach_in(tach), .fan_pwm_q(pwm));
    fan_model #(.HALF(HALF)) i_fan_model (.clk(clk), .pwm(pwm), .tach(tach));

    initial forever #10 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Highest table step whose temperature is not above t wins.
    function automatic int lut(int t);
        int e = 0;
        for (int i = 0; i < 8; i++) if (25 + 10 * i <= t) e = 8 + i;
        return e;
    endfunction

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk) req <= '{1'b1, 1'b0, a, w};
        @(posedge clk) req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1 r = rdata;
    endtask

    // Any window of four whole periods holds exactly four rises at partial duty, none at zero or full duty.
    task automatic meas(input int f, input int d, input bit pol, input int base);
        int   p = 2 * ((f == 0) ? 1 : f) * base;
        int   e = ((d > p / base) ? p / base : d) * base;
        int   h = 0;
        int   r = 0;
        logic last;
        repeat (p + 4) @(posedge clk);
        #1 last = pwm;
        repeat (4 * p) begin
            @(posedge clk);
            #1;
            if (pwm === 1'b1) h++;
            if (pwm === 1'b1 && last === 1'b0) r++;
            last = pwm;
        end
        check("pwm_high", 16'(pol ? 4 * (p - e) : 4 * e), h[15:0]);
        check("pwm_rises", 16'((e > 0 && e < p) ? 4 : 0), r[15:0]);
    endtask

    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Worst case is about 59,000 cycles, most of it waiting on tach edges.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(FAN_CFG_ADDR, v);
        check("cfg_reset", FAN_CFG_RESET, v);
        rd(8'h60, v);
        check("unmapped", 8'h00, v);
        // Setup order first, with reserved bits set to prove the masks.
        wr(FAN_CFG_ADDR, 8'hFF);
        lo = 8'(rnd());
        wr(SPINUP_ADDR, lo);
        wr(FREQ_ADDR, 8'hFF);
        wr(DUTY_ADDR, 8'h00);
        rd(FAN_CFG_ADDR, v);
        check("cfg", 8'h3B, v);
        rd(FREQ_ADDR, v);
        check("freq", 8'h1F, v);
        rd(SPINUP_ADDR, v);
        check("spinup", lo & SPINUP_MASK, v);
        for (int i = 0; i < 12; i++) begin
            f = (i < 3) ? cf[i] : rnd() % 32;
            d = (i < 3) ? cd[i] : rnd() % 64;
            pol = (i < 3) ? 1'b0 : (i == 3) ? 1'b1 : 1'(rnd());
            wr(FREQ_ADDR, f[7:0]);
            wr(DUTY_ADDR, d[7:0]);
            wr(FAN_CFG_ADDR, {3'b001, pol, 4'b1000});
            meas(f, d, pol, SLOW);
        end
        wr(FAN_CFG_ADDR, 8'h20);
        wr(FREQ_ADDR, 8'h01);
        wr(DUTY_ADDR, 8'h01);
        meas(1, 1, 1'b0, FAST);
        // Table mode: temperatures ascend, PWM values differ per step.
        wr(FAN_CFG_ADDR, 8'h28);
        wr(FREQ_ADDR, 8'h14);
        for (int i = 0; i < 8; i++) begin
            wr(LUT_FIRST_ADDR + 8'(2 * i), 8'(25 + 10 * i));
            wr(LUT_FIRST_ADDR + 8'(2 * i + 1), 8'(8 + i));
        end
        wr(FAN_CFG_ADDR, 8'h08);
        rd(LUT_FIRST_ADDR + 8'h03, v);
        check("lut", 8'h09, v);
        for (int i = 0; i < 5; i++) begin
            f = (i == 0) ? 24 : (i == 1) ? 35 : (i == 2) ? 105 : rnd() % 120;
            @(posedge clk) temp <= f[7:0];
            meas(20, lut(f), 1'b0, SLOW);
        end
        // Four edges guarantee a latch that spans two whole tach periods.
        repeat (4) @(posedge tach);
        repeat (3) @(posedge clk);
        rd(TACH_LOW_ADDR, lo);
        rd(TACH_HIGH_ADDR, v);
        f = 256 * v + lo;
        check("tach", 16'(1), 16'((f >= TACH_EXP - 1 && f <= TACH_EXP + 1) ? 1 : 0));
        d = (f > 0) ? 5_400_000 / f - RPM_EXP : RPM_EXP;
        check("rpm", 16'(1), 16'((20 * (d < 0 ? -d : d) <= RPM_EXP) ? 1 : 0));
        test_done();
    end
endmodule
